// ---- common/pll_ctrl_pkg.sv ----
// Shared constants and types of the dual synthesizer control logic.
// Assumes one 40 MHz clock; every pin is sampled as a synchronous input.
package pll_ctrl_pkg;

  // ************************************************************
  // Clock, programming word and latch selection
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SHIFT_W = 22;
  localparam logic [21:0] LATCH_RST = 22'h000000;
  localparam logic [1:0] SEL_IF_REF = 2'h0;
  localparam logic [1:0] SEL_IF_AB = 2'h1;
  localparam logic [1:0] SEL_RF_REF = 2'h2;
  localparam logic [1:0] SEL_RF_AB = 2'h3;
  localparam int SEL_KIND_BIT = 0;
  localparam int SEL_SIDE_BIT = 1;
  localparam int PD_BIT = 21;

  // ************************************************************
  // Counter widths and prescaler moduli (lower modulus P)
  // ************************************************************
  localparam int R_W = 14;
  localparam int A_W = 6;
  localparam int B_W = 11;
  localparam int PRE_W = 7;
  localparam logic [6:0] IF_P_SEL0 = 7'h08;
  localparam logic [6:0] IF_P_SEL1 = 7'h10;
  localparam logic [6:0] RF_P_SEL0 = 7'h40;
  localparam logic [6:0] RF_P_SEL1 = 7'h20;

  // ************************************************************
  // Lock detection timing
  // ************************************************************
  localparam int LOCK_WIDTH_NS = 50;
  localparam logic [3:0] LOCK_WIDTH_CYC = 4'(LOCK_WIDTH_NS / CLK_PERIOD_NS);
  localparam logic [1:0] LOCK_COUNT = 2'h3;

  // ************************************************************
  // Latch layouts, bit 21 down to bit 0
  // ************************************************************
  typedef struct packed {
    logic outSelHi;
    logic outSelLo;
    logic pumpTri;
    logic pumpGain;
    logic pfdPol;
    logic spare;
    logic [R_W-1:0] rCount;
    logic [1:0] ctrl;
  } ref_latch_t;

  typedef struct packed {
    logic powerDown;
    logic prescSel;
    logic [B_W-1:0] bCount;
    logic spare;
    logic [A_W-1:0] aCount;
    logic [1:0] ctrl;
  } ab_latch_t;

  typedef struct packed {
    logic en;
    logic up;
    logic dn;
  } pump_t;

  // ************************************************************
  // Modes and states
  // ************************************************************
  typedef enum logic [3:0] {
    MUX_LOW = 4'h0, MUX_IF_LOCK = 4'h1, MUX_RF_LOCK = 4'h2,
    MUX_BOTH_LOCK = 4'h3, MUX_IF_REF = 4'h4, MUX_IF_FB = 4'h5,
    MUX_RF_REF = 4'h6, MUX_RF_FB = 4'h7, MUX_IF_RST = 4'h8,
    MUX_RF_RST = 4'h9, MUX_ALL_RST = 4'ha, MUX_HIGH = 4'hf
  } mux_sel_t;

  typedef enum logic [2:0] {
    PD_RUN = 3'b001, PD_DRAIN = 3'b010, PD_DOWN = 3'b100
  } pd_state_t;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [A_W-1:0] swal;
    logic [B_W-1:0] main;
    logic pulse;
  } sw_state_t;

  typedef struct packed {
    logic [R_W-1:0] cnt;
    logic pulse;
  } rd_state_t;

endpackage : pll_ctrl_pkg

// ---- core/pll_control.sv ----
// Digital control of a dual synthesizer: serial loading, latches,
// dividers, phase detectors, lock detect, output select, power-down.
// Assumes serial pins, reference and oscillator inputs are synchronous
// to clk and change far slower than it.
`timescale 1ns/1ps
module pll_control import pll_ctrl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Three-wire programming port
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadStrobe,
  // Reference and oscillator inputs, index 0 is IF, 1 is RF
  input wire logic refClkIn,
  input wire logic [1:0] vcoIn,
  // Status output and reference buffer control
  output logic mux_status_output,
  output logic refBufEn,
  // Charge pump controls
  output pump_t ifPump,
  output pump_t rfPump
);

  // ************************************************************
  // State and working signals
  // ************************************************************
  typedef struct packed {
    logic [SHIFT_W-1:0] shiftReg;
    logic lastSclk;
    logic lastLoad;
    logic lastRef;
    logic [1:0] lastVco;
    ref_latch_t [1:0] refL;
    ab_latch_t [1:0] abL;
    pd_state_t [1:0] pd;
    logic [1:0] up;
    logic [1:0] dn;
    logic [1:0][3:0] errCnt;
    logic [1:0][1:0] goodCnt;
    logic [1:0] locked;
    pump_t [1:0] pump;
    logic mux;
    logic refEn;
  } ctl_t;

  ctl_t s_reg, s_next;
  mux_sel_t sel;
  logic [1:0] ctrRst;
  logic [1:0] hold;
  logic [1:0] lockLvl;
  logic [1:0] pdReq;
  logic [1:0][PRE_W-1:0] presc;
  logic [1:0] rPulse;
  logic [1:0] nPulse;
  logic refStep;
  logic [1:0] vcoStep;
  logic loadEv;

  // Edges of the sampled pins; the reference path is cut while both
  // sides are down so the pin sees no switching load.
  assign loadEv = loadStrobe && !s_reg.lastLoad;
  assign refStep = refClkIn && !s_reg.lastRef && s_reg.refEn;
  assign vcoStep = vcoIn & ~s_reg.lastVco;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.lastSclk = serialClk;
    s_next.lastLoad = loadStrobe;
    s_next.lastRef = refClkIn;
    s_next.lastVco = vcoIn;
    // Output select is split over both reference latches.
    sel = mux_sel_t'({s_reg.refL[1].outSelHi, s_reg.refL[1].outSelLo,
                      s_reg.refL[0].outSelHi, s_reg.refL[0].outSelLo});
    ctrRst[0] = sel == MUX_IF_RST || sel == MUX_ALL_RST;
    ctrRst[1] = sel == MUX_RF_RST || sel == MUX_ALL_RST;
    presc[0] = s_reg.abL[0].prescSel ? IF_P_SEL1 : IF_P_SEL0;
    presc[1] = s_reg.abL[1].prescSel ? RF_P_SEL1 : RF_P_SEL0;

    // Serial word enters at bit 0, so the first bit ends up at the top.
    if (serialClk && !s_reg.lastSclk) begin
      s_next.shiftReg = {s_reg.shiftReg[SHIFT_W-2:0], serialData};
    end

    // Bit 1 picks the side, bit 0 picks reference or divider latch.
    // Loading is never blocked, whatever the power state.
    if (loadEv) begin
      if (!s_reg.shiftReg[SEL_KIND_BIT]) begin
        s_next.refL[s_reg.shiftReg[SEL_SIDE_BIT]] =
          ref_latch_t'(s_reg.shiftReg);
      end else begin
        s_next.abL[s_reg.shiftReg[SEL_SIDE_BIT]] =
          ab_latch_t'(s_reg.shiftReg);
      end
    end

    for (int i = 0; i < 2; i++) begin
      // Power state follows the freshly latched bit so an asynchronous
      // entry or a wake-up lands on the strobe edge itself.
      pdReq[i] = s_next.abL[i].powerDown;
      case (s_reg.pd[i])
        PD_RUN: begin
          if (pdReq[i]) begin
            s_next.pd[i] = s_reg.refL[i].pumpTri ? PD_DOWN
                                                 : PD_DRAIN;
          end
        end
        PD_DRAIN: begin
          s_next.pd[i] = pdReq[i] ? PD_DOWN : PD_RUN;
        end
        PD_DOWN: begin
          if (!pdReq[i]) begin
            s_next.pd[i] = PD_RUN;
          end
        end
        default: begin
          s_next.pd[i] = PD_RUN;
        end
      endcase

      // Both dividers of a side release together, so the feedback
      // count restarts in step with the reference count.
      hold[i] = ctrRst[i] || s_reg.pd[i] == PD_DOWN;

      // Phase detector: each divider pulse sets its flag, both set
      // clears both. A held side also loses its lock history.
      if (hold[i]) begin
        s_next.up[i] = 1'b0;
        s_next.dn[i] = 1'b0;
        s_next.errCnt[i] = '0;
        s_next.goodCnt[i] = '0;
        s_next.locked[i] = 1'b0;
      end else begin
        s_next.up[i] = s_reg.up[i] || rPulse[i];
        s_next.dn[i] = s_reg.dn[i] || nPulse[i];
        if (s_next.up[i] && s_next.dn[i]) begin
          s_next.up[i] = 1'b0;
          s_next.dn[i] = 1'b0;
        end
        if ((s_reg.up[i] || s_reg.dn[i]) && s_reg.errCnt[i] != 4'hf) begin
          s_next.errCnt[i] = s_reg.errCnt[i] + 4'h1;
        end
        // Lock needs several comparison periods of narrow error.
        if (rPulse[i]) begin
          s_next.errCnt[i] = '0;
          if (s_reg.errCnt[i] > LOCK_WIDTH_CYC) begin
            s_next.goodCnt[i] = '0;
          end else if (s_reg.goodCnt[i] != LOCK_COUNT) begin
            s_next.goodCnt[i] = s_reg.goodCnt[i] + 2'h1;
          end
        end
        s_next.locked[i] = s_next.goodCnt[i] == LOCK_COUNT;
      end

      // Pump idles for its own bit, counter reset or any power step.
      s_next.pump[i].en = !(s_reg.refL[i].pumpTri || ctrRst[i] ||
                            s_reg.pd[i] != PD_RUN);
      s_next.pump[i].up = s_next.pump[i].en &&
        (s_reg.refL[i].pfdPol ? s_reg.up[i] : s_reg.dn[i]);
      s_next.pump[i].dn = s_next.pump[i].en &&
        (s_reg.refL[i].pfdPol ? s_reg.dn[i] : s_reg.up[i]);

      // Locked level dips low for each live detector pulse.
      lockLvl[i] = s_reg.locked[i] && !s_reg.up[i] && !s_reg.dn[i];
    end

    // Fastlock takes the pin low to ground the extra damping resistor.
    if (s_reg.refL[1].pumpGain) begin
      s_next.mux = 1'b0;
    end else begin
      case (sel)
        MUX_IF_LOCK: s_next.mux = lockLvl[0];
        MUX_RF_LOCK: s_next.mux = lockLvl[1];
        MUX_BOTH_LOCK: s_next.mux = lockLvl[0] && lockLvl[1];
        MUX_IF_REF: s_next.mux = rPulse[0];
        MUX_IF_FB: s_next.mux = nPulse[0];
        MUX_RF_REF: s_next.mux = rPulse[1];
        MUX_RF_FB: s_next.mux = nPulse[1];
        MUX_HIGH: s_next.mux = 1'b1;
        default: s_next.mux = 1'b0;
      endcase
    end

    // The reference path is shared, so it is cut only when both are down.
    s_next.refEn = !(s_next.pd[0] == PD_DOWN &&
                     s_next.pd[1] == PD_DOWN);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.refL <= {LATCH_RST, LATCH_RST};
      s_reg.abL <= {LATCH_RST, LATCH_RST};
      s_reg.pd <= {PD_RUN, PD_RUN};
      s_reg.refEn <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mux_status_output = s_reg.mux;
  assign refBufEn = s_reg.refEn;
  assign ifPump = s_reg.pump[0];
  assign rfPump = s_reg.pump[1];

  // ************************************************************
  // Dividers, one pair per side
  // ************************************************************
  for (genvar g = 0; g < 2; g++) begin : gSide
    ref_divider uRef (
      .clk(clk),
      .nrst(nrst),
      .hold(hold[g]),
      .step(refStep),
      .ratio(s_reg.refL[g].rCount),
      .pulse(rPulse[g])
    );
    swallow_divider uFb (
      .clk(clk),
      .nrst(nrst),
      .hold(hold[g]),
      .step(vcoStep[g]),
      .presc(presc[g]),
      .aLoad(s_reg.abL[g].aCount),
      .bLoad(s_reg.abL[g].bCount),
      .pulse(nPulse[g])
    );
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_SHIFT_MSB_FIRST: assert property (
    (serialClk && !s_reg.lastSclk) |=> s_reg.shiftReg[0] == $past(serialData)
      && s_reg.shiftReg[SHIFT_W-1:1] == $past(s_reg.shiftReg[SHIFT_W-2:0]))
    else $error("Serial bit not shifted in at the bottom.");
  AST_LATCH_IF_AB: assert property (
    (loadEv && s_reg.shiftReg[1:0] == SEL_IF_AB)
      |=> s_reg.abL[0] == $past(s_reg.shiftReg))
    else $error("IF divider latch did not take the word.");
  AST_LATCH_RF_REF: assert property (
    (loadEv && s_reg.shiftReg[1:0] == SEL_RF_REF)
      |=> s_reg.refL[1] == $past(s_reg.shiftReg) && $stable(s_reg.abL))
    else $error("RF reference latch select wrong.");
  AST_SYNC_PD: assert property (
    (s_reg.pd[0] == PD_RUN && !s_reg.refL[0].pumpTri && loadEv &&
     s_reg.shiftReg[1:0] == SEL_IF_AB && s_reg.shiftReg[PD_BIT])
      |=> s_reg.pd[0] == PD_DRAIN ##1 (s_reg.pd[0] == PD_DOWN && !ifPump.en))
    else $error("Synchronous power-down sequence wrong.");
  AST_ASYNC_PD: assert property (
    (s_reg.pd[1] == PD_RUN && s_reg.refL[1].pumpTri && loadEv &&
     s_reg.shiftReg[1:0] == SEL_RF_AB && s_reg.shiftReg[PD_BIT])
      |=> s_reg.pd[1] == PD_DOWN)
    else $error("Asynchronous power-down not on the strobe edge.");
  AST_PD_HOLD: assert property (
    s_reg.pd[0] == PD_DOWN |=> !rPulse[0] && !nPulse[0])
    else $error("Powered-down dividers still run.");
  AST_WAKE: assert property (
    (s_reg.pd[1] == PD_DOWN && loadEv && s_reg.shiftReg[1:0] == SEL_RF_AB &&
     !s_reg.shiftReg[PD_BIT]) |=> s_reg.pd[1] == PD_RUN)
    else $error("Side did not wake on cleared power-down bit.");
  AST_REF_OFF: assert property (
    (s_reg.pd[0] == PD_DOWN && s_reg.pd[1] == PD_DOWN) |-> !refBufEn)
    else $error("Reference path connected while powered down.");
  AST_FASTLOCK: assert property (
    s_reg.refL[1].pumpGain |=> !mux_status_output)
    else $error("Fastlock output not driven low.");
  AST_BOTH_LOCK: assert property (
    (sel == MUX_BOTH_LOCK && !s_reg.refL[1].pumpGain &&
     !(s_reg.locked[0] && s_reg.locked[1])) |=> !mux_status_output)
    else $error("Combined lock shown with a loop unlocked.");
  AST_LOCK_PULSE: assert property (
    (sel == MUX_IF_LOCK && !s_reg.refL[1].pumpGain &&
     (s_reg.up[0] || s_reg.dn[0] || !s_reg.locked[0])) |=> !mux_status_output)
    else $error("Lock level high during detector pulse or unlock.");
  AST_CTR_RST: assert property (
    sel == MUX_ALL_RST |=> !ifPump.en && !rfPump.en && rPulse == 2'b00)
    else $error("Counter reset did not hold both sides.");

  CV_SYNC_PD: cover property (s_reg.pd[0] == PD_DRAIN ##1
                              s_reg.pd[0] == PD_DOWN);
  CV_BOTH_LOCKED: cover property (sel == MUX_BOTH_LOCK && mux_status_output);
  CV_FASTLOCK: cover property (s_reg.refL[1].pumpGain ##1 !mux_status_output);

endmodule : pll_control

// ---- core/ref_divider.sv ----
// Programmable reference divider producing one comparison pulse per ratio.
// Assumes step is a one-cycle pulse per reference input edge.
`timescale 1ns/1ps
module ref_divider import pll_ctrl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic hold,
  input wire logic step,
  input wire logic [R_W-1:0] ratio,
  // Result
  output logic pulse
);

  rd_state_t s_reg, s_next;
  logic [R_W-1:0] gap;
  logic seen;
  logic [R_W-1:0] ratioLast;

  // A ratio of zero behaves as divide by one.
  always_comb begin
    s_next = s_reg;
    s_next.pulse = 1'b0;
    if (hold) begin
      s_next.cnt = '0;
    end else if (step) begin
      if (s_reg.cnt + 14'h1 >= ratio) begin
        s_next.cnt = '0;
        s_next.pulse = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 14'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pulse = s_reg.pulse;

  // Step counter between pulses, only for the check below.
  always_ff @(posedge clk) begin
    if (!nrst || hold || ratio != ratioLast) begin
      gap <= '0;
      seen <= 1'b0;
    end else if (step) begin
      gap <= s_next.pulse ? '0 : gap + 14'h1;
      if (s_next.pulse) begin
        seen <= 1'b1;
      end
    end
    ratioLast <= ratio;
  end

  AST_REF_RATIO: assert property (@(posedge clk) disable iff (!nrst)
    (step && s_next.pulse && seen && ratio != '0) |-> gap + 14'h1 == ratio)
    else $error("Reference divider period differs from the ratio.");

endmodule : ref_divider

// ---- core/swallow_divider.sv ----
// Dual-modulus prescaler with swallow and main counters (feedback divider).
// Assumes step is a one-cycle pulse per oscillator input edge.
`timescale 1ns/1ps
module swallow_divider import pll_ctrl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic hold,
  input wire logic step,
  input wire logic [PRE_W-1:0] presc,
  input wire logic [A_W-1:0] aLoad,
  input wire logic [B_W-1:0] bLoad,
  // Result
  output logic pulse
);

  sw_state_t s_reg, s_next;
  logic [PRE_W-1:0] modulus;
  logic [17:0] gap;
  logic [17:0] expRatio;
  logic seen;
  logic [23:0] cfgLast;

  // Higher modulus while swallow count remains, then lower modulus.
  always_comb begin
    modulus = (s_reg.swal != '0) ? presc + 7'h1 : presc;
    s_next = s_reg;
    s_next.pulse = 1'b0;
    if (hold) begin
      s_next.pre = '0;
      s_next.swal = aLoad;
      s_next.main = bLoad;
    end else if (step) begin
      if (s_reg.pre + 7'h1 >= modulus) begin
        s_next.pre = '0;
        if (s_reg.swal != '0) begin
          s_next.swal = s_reg.swal - 6'h1;
        end
        if (s_reg.main <= 11'h1) begin
          s_next.main = bLoad;
          s_next.swal = aLoad;
          s_next.pulse = 1'b1;
        end else begin
          s_next.main = s_reg.main - 11'h1;
        end
      end else begin
        s_next.pre = s_reg.pre + 7'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pulse = s_reg.pulse;

  // Input edges between output pulses, only for the check below.
  // Operands are widened first so that the product cannot wrap.
  assign expRatio = 18'(presc) * 18'(bLoad) + 18'(aLoad);
  always_ff @(posedge clk) begin
    if (!nrst || hold || {presc, aLoad, bLoad} != cfgLast) begin
      gap <= '0;
      seen <= 1'b0;
    end else if (step) begin
      gap <= s_next.pulse ? '0 : gap + 18'h1;
      if (s_next.pulse) begin
        seen <= 1'b1;
      end
    end
    cfgLast <= {presc, aLoad, bLoad};
  end

  AST_N_RATIO: assert property (@(posedge clk) disable iff (!nrst)
    (step && s_next.pulse && seen && bLoad >= 11'(aLoad) && bLoad != '0)
    |-> gap + 18'h1 == expRatio)
    else $error("Feedback period differs from B times P plus A.");

endmodule : swallow_divider

// ---- dv/pll_control_tb.sv ----
// Self-checking bench of the dual synthesizer control logic.
// Assumes the host model serial_host; inputs change at the falling edge.
`timescale 1ns/1ps
module pll_control_tb;
  import pll_ctrl_pkg::*;
  logic clk, nrst, refClkIn, mux_status_output, refBufEn;
  logic serialClk, serialData, loadStrobe;
  logic [1:0] vcoIn;
  pump_t ifPump, rfPump;
  int numErrors, totalChecks;

  // ************************************************************
  // Clock, design and host
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  pll_control dut_u (.clk(clk), .nrst(nrst), .serialClk(serialClk),
    .serialData(serialData), .loadStrobe(loadStrobe),
    .refClkIn(refClkIn), .vcoIn(vcoIn), .mux_status_output(mux_status_output),
    .refBufEn(refBufEn), .ifPump(ifPump), .rfPump(rfPump));
  serial_host host_u (.clk(clk), .serialClk(serialClk),
    .serialData(serialData), .loadStrobe(loadStrobe));

  // ************************************************************
  // Helpers
  // ************************************************************
  // Compares one result; case equality keeps unknowns from matching.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      numErrors++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  // Reference latch word; detector polarity is left normal.
  function automatic logic [21:0] rw(input logic s, input logic [1:0] m,
    input logic t, input logic g, input logic [13:0] r);
    return {m, t, g, 1'b1, 1'b0, r, s, 1'b0};
  endfunction : rw

  // Divider latch word.
  function automatic logic [21:0] abw(input logic s, input logic pd,
    input logic ps, input logic [10:0] b, input logic [5:0] a);
    return {pd, ps, b, 1'b0, a, s, 1'b1};
  endfunction : abw

  // Sets the output select code and both reference ratios.
  task automatic setSel(input logic [3:0] c, input logic [13:0] r,
                        input logic g);
    host_u.send(rw(1'b1, c[3:2], 1'b0, g, r));
    host_u.send(rw(1'b0, c[1:0], 1'b0, 1'b0, r));
  endtask : setSel

  // Gives n edges on one input (0 ref, 1 IF, 2 RF), counts output pulses.
  task automatic edges(input int w, input int n, output int cnt);
    cnt = 0;
    for (int i = 0; i < n + 1; i++) begin
      for (int k = 0; k < 4; k++) begin
        @(negedge clk);
        if (mux_status_output === 1'b1) cnt++;
        if (i < n && k == 0) {vcoIn, refClkIn} = 3'(1 << w);
        if (k == 2) {vcoIn, refClkIn} = 3'h0;
      end
    end
  endtask : edges

  task automatic stopTest;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stopTest

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Codes f and 0 need the right bits in both reference latches.
  task automatic tSelect;
    setSel(4'hf, 14'h1, 1'b0);
    chk("mux_status_output high", 1, mux_status_output);
    setSel(4'h0, 14'h1, 1'b0);
    chk("mux_status_output low", 0, mux_status_output);
    setSel(4'hf, 14'h1, 1'b1);
    chk("fastlock", 0, mux_status_output);
  endtask : tSelect

  // Counter reset idles only the chosen side's pump.
  task automatic tCntReset;
    setSel(4'h8, 14'h1, 1'b0);
    chk("if pump en", 0, ifPump.en);
    chk("rf pump en", 1, rfPump.en);
    setSel(4'h9, 14'h1, 1'b0);
    chk("if pump en", 1, ifPump.en);
    chk("rf pump en", 0, rfPump.en);
    setSel(4'ha, 14'h1, 1'b0);
    chk("if pump en", 0, ifPump.en);
    chk("rf pump en", 0, rfPump.en);
  endtask : tCntReset

  // Three comparison periods of ratio 3 after a counter reset.
  task automatic tRefDiv;
    int cnt;
    setSel(4'ha, 14'h3, 1'b0);
    setSel(4'h4, 14'h3, 1'b0);
    edges(0, 9, cnt);
    chk("ref pulses", 3, cnt);
  endtask : tRefDiv

  // Two feedback periods of ratio n = b*P+a on one side.
  task automatic tFb(input logic s, input logic ps, input logic [10:0] b,
                     input logic [5:0] a, input int n);
    int cnt;
    host_u.send(abw(s, 1'b0, ps, b, a));
    setSel(4'ha, 14'h1, 1'b0);
    setSel(s ? 4'h7 : 4'h5, 14'h1, 1'b0);
    edges(s + 1, 2 * n, cnt);
    chk("fb pulses", 2, cnt);
  endtask : tFb

  // IF loop held in lock: one reference edge on every eighth IF edge,
  // so both detector inputs pulse together; RF never sees feedback.
  task automatic tLock;
    host_u.send(abw(1'b0, 1'b0, 1'b0, 11'h1, 6'h0));
    setSel(4'ha, 14'h1, 1'b0);
    setSel(4'h1, 14'h1, 1'b0);
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      vcoIn[0] = 1'b1;
      refClkIn = (i % 8 == 7);
      repeat (2) @(negedge clk);
      {vcoIn, refClkIn} = 3'h0;
      @(negedge clk);
    end
    chk("if lock", 1, mux_status_output);
    setSel(4'h3, 14'h1, 1'b0);
    chk("both lock", 0, mux_status_output);
  endtask : tLock

  // Power-down per side; reference path cut only when both are down.
  task automatic tPowerDown;
    host_u.send(abw(1'b0, 1'b1, 1'b0, 11'h1, 6'h0));
    chk("if pd pump", 0, ifPump.en);
    chk("ref path", 1, refBufEn);
    host_u.send(rw(1'b1, 2'h0, 1'b1, 1'b0, 14'h1));
    host_u.send(abw(1'b1, 1'b1, 1'b0, 11'h1, 6'h0));
    chk("ref path", 0, refBufEn);
    host_u.send(abw(1'b0, 1'b0, 1'b0, 11'h1, 6'h0));
    chk("if pump en", 1, ifPump.en);
    chk("ref path", 1, refBufEn);
    host_u.send(abw(1'b1, 1'b0, 1'b0, 11'h1, 6'h0));
    host_u.send(rw(1'b1, 2'h0, 1'b0, 1'b0, 14'h1));
    chk("rf pump en", 1, rfPump.en);
  endtask : tPowerDown

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    numErrors = 0;
    totalChecks = 0;
    nrst = 1'b0;
    refClkIn = 1'b0;
    vcoIn = 2'h0;
    repeat (5) @(negedge clk);
    chk("pump in reset", 0, ifPump);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    chk("mux_status_output reset", 0, mux_status_output);
    chk("ref path reset", 1, refBufEn);
    tSelect();
    tCntReset();
    tRefDiv();
    tFb(1'b0, 1'b0, 11'h2, 6'h1, 17);
    tFb(1'b0, 1'b1, 11'h2, 6'h1, 33);
    tFb(1'b0, 1'b0, 11'h3f, 6'h3f, 567);
    tFb(1'b1, 1'b0, 11'h1, 6'h0, 64);
    tFb(1'b1, 1'b1, 11'h3, 6'h3, 99);
    tLock();
    tPowerDown();
    stopTest();
  end

  // A hang is cut short well inside the cycle budget.
  initial begin
    #2000000;
    numErrors++;
    stopTest();
  end
endmodule : pll_control_tb

// ---- dv/serial_host.sv ----
// Host model that drives the three-wire programming port.
// Assumes a free-running clk; every pin changes at its falling edge.
`timescale 1ns/1ps
module serial_host (
  // Clock
  input wire logic clk,
  // Programming pins
  output logic serialClk,
  output logic serialData,
  output logic loadStrobe
);
  // ************************************************************
  // Idle levels
  // ************************************************************
  // Pins start low so the first rise after reset counts as an edge.
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadStrobe = 1'b0;
  end

  // ************************************************************
  // Word transfer
  // ************************************************************
  // Sends one word MSB first, then strobes it into its latch.
  task automatic send(input logic [21:0] w);
    for (int i = 21; i >= 0; i--) begin
      @(negedge clk);
      serialData = w[i];
      serialClk = 1'b1;
      @(negedge clk);
      serialClk = 1'b0;
    end
    // The data line has no pull, so it must not keep the last bit.
    @(negedge clk);
    serialData = ~serialData;
    loadStrobe = 1'b1;
    repeat (2) @(negedge clk);
    loadStrobe = 1'b0;
    repeat (3) @(negedge clk);
  endtask : send
endmodule : serial_host
